// File: rtl/vbus_monitor_discharge_ctrl.sv
// Purpose: VBUS supervision, alarms, manual and automatic discharge, alert watchdog
// Assumes: Converter and CC comparators outside; AHB-Lite slave, zero wait states
// Notes: Behaviour
// Behaviour
// - Sample VBUS periodically and publish each result, 25 mV per step.
// - Bus-present bit follows threshold; port-power alert when status AND mask nonzero.
// - High and low thresholds crossed raise high and low alarm alerts.
// - Alarm-disable bit suppresses both voltage alarms.
// - Bleed enable bit connects the bleed load, at most seven kilohms.
// - Forced discharge bit applies the full load, slew at most 30 mV/us.
// - Source mode follows source path; open selected CC means disconnect, full load.
// - Disconnect discharge reaches safe five volts and zero volts within deadlines.
// - Power-role field zero means sink.
// - High-voltage sink uses threshold; safe-five sink uses bus-present falling.
// - High-voltage sink with automatic discharge keeps bleed load until below sink threshold.
// - Sink disconnect seen within 6 ms, then full load to zero volts.
// - Terminations withheld and automatic discharge stops at safe zero volts.
// - Not at zero volts after 650 ms sets fault and failure, load stays.
// - Forced discharge ends itself at the stop-discharge threshold while connected.
// - Watchdog runs only with its enable bit set; software sets it after attach.
// - Watchdog starts on pending alert or pin, clears on any bus access.
// - Expiry opens role bits 1111b, drops paths, discharges, flags interface error.
// - Detach drops source and sink path outputs.
`timescale 1ns/1ns
`default_nettype none
module vbus_monitor_discharge_ctrl #(
  parameter int unsigned SAMPLE_CYC = vbus_pkg::SAMPLE_CYCLES,
  parameter int unsigned WATCHDOG_CYC = vbus_pkg::WATCHDOG_CYCLES,
  parameter int unsigned SAFE5V_CYC = vbus_pkg::SAFE5V_CYCLES,
  parameter int unsigned ZERO_VOLT_CYC = vbus_pkg::ZERO_VOLT_CYCLES,
  parameter int unsigned DISC_FILTER_CYC = vbus_pkg::DISC_FILTER_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic adc_sample_o,
  input wire logic adc_valid_i,
  input wire logic [9:0] adc_result_i,
  input wire logic bus_power_present_i,
  input wire logic [1:0] cc1_pin_state_i,
  input wire logic [1:0] cc2_pin_state_i,
  output logic source_path_o,
  output logic sink_path_o,
  output logic bleed_load_o,
  output logic full_discharge_load_o,
  output logic cc_term_enable_o,
  output logic [3:0] role_control_o,
  output logic interrupt_pin_n_o
);
  import vbus_pkg::*;

  typedef enum logic [0:0] {DC_WATCH, DC_DISCH} dc_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  pwr_ctrl_t pctrl_r;
  path_t path_r;
  logic plug_orientation_r, wd_en_r, msg_role_r;
  logic [3:0] pmask_r, amask_r, role_r;
  logic [3:1] alert_r;
  logic [1:0] fault_r;
  logic [9:0] volt_r, hi_thr_r, lo_thr_r, snk_thr_r, stop_thr_r;
  logic [3:0] pstat;
  logic pp_alert_r;
  logic [2:0] vp_s;
  logic [1:0] cc1_s [3];
  logic [1:0] cc2_s [3];
  logic vp_f_r, vp_prev_r;
  logic [1:0] cc1_f_r, cc2_f_r;
  logic [31:0] samp_cnt_r, disc_cnt_r, low_cnt_r, wd_cnt_r;
  logic new_sample_r;
  dc_state_t state_r;
  logic hv_sink_r, wd_disch_r, wd_expire_r, auto_bleed;
  logic src_disc, snk_disc, disconnect, disc_timeout, safe5_late;
  logic dp_write_r, access;
  logic [7:0] dp_addr_r;

  function automatic logic [31:0] reg_read(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0;
    unique case (ofs)
      OFS_PWR_CTRL: v[3:0] = pctrl_r;
      OFS_PORT_CTRL: v[1:0] = {wd_en_r, plug_orientation_r};
      OFS_PWR_STAT: v[3:0] = pstat;
      OFS_PWR_MASK: v[3:0] = pmask_r;
      OFS_ALERT: v[3:0] = {alert_r, pp_alert_r};
      OFS_ALERT_MASK: v[3:0] = amask_r;
      OFS_FAULT: v[1:0] = fault_r;
      OFS_VOLT: v[9:0] = volt_r;
      OFS_HI_THR: v[9:0] = hi_thr_r;
      OFS_LO_THR: v[9:0] = lo_thr_r;
      OFS_SNK_THR: v[9:0] = snk_thr_r;
      OFS_STOP_THR: v[9:0] = stop_thr_r;
      OFS_MSG_HDR: v[0] = msg_role_r;
      OFS_COMMAND: v[1:0] = path_r;
      OFS_ROLE: v[3:0] = role_r;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  function automatic logic wr_hit(input logic [7:0] ofs);
    return dp_write_r && (dp_addr_r == ofs);
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait, always OKAY
  // ----------------------------------------------------------------
  assign access = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dp_write_r <= 1'b0;
      dp_addr_r <= 8'h0;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      dp_write_r <= access && hwrite_i;
      dp_addr_r <= {haddr_i[7:2], 2'b00};
      // Read data sampled at the address phase; unmapped offsets read zero
      if (access && !hwrite_i) begin
        hrdata_o <= (haddr_i[31:8] == 24'h0) ? reg_read({haddr_i[7:2], 2'b00}) : 32'h0;
      end
      if (access && haddr_i[31:8] != 24'h0) begin
        dp_write_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers: accept when second and third stage agree
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      vp_s <= 3'h0;
      cc1_s <= '{default: 2'h0};
      cc2_s <= '{default: 2'h0};
      vp_f_r <= 1'b0;
      vp_prev_r <= 1'b0;
      cc1_f_r <= 2'h0;
      cc2_f_r <= 2'h0;
    end else begin
      vp_s <= {vp_s[1:0], bus_power_present_i};
      cc1_s <= '{cc1_pin_state_i, cc1_s[0], cc1_s[1]};
      cc2_s <= '{cc2_pin_state_i, cc2_s[0], cc2_s[1]};
      if (vp_s[1] == vp_s[2]) begin
        vp_f_r <= vp_s[2];
      end
      if (cc1_s[1] == cc1_s[2]) begin
        cc1_f_r <= cc1_s[2];
      end
      if (cc2_s[1] == cc2_s[2]) begin
        cc2_f_r <= cc2_s[2];
      end
      vp_prev_r <= vp_f_r;
    end
  end

  // ----------------------------------------------------------------
  // Converter sampling
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      samp_cnt_r <= 32'h0;
      adc_sample_o <= 1'b0;
      volt_r <= 10'h0;
      new_sample_r <= 1'b0;
    end else begin
      adc_sample_o <= (samp_cnt_r == SAMPLE_CYC - 1);
      samp_cnt_r <= (samp_cnt_r == SAMPLE_CYC - 1) ? 32'h0 : samp_cnt_r + 32'h1;
      new_sample_r <= adc_valid_i;
      if (adc_valid_i) begin
        volt_r <= adc_result_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      plug_orientation_r <= 1'b0;
      wd_en_r <= 1'b0;
      msg_role_r <= 1'b0;
      pmask_r <= MASK_RST;
      amask_r <= MASK_RST;
      hi_thr_r <= HI_THR_RST;
      lo_thr_r <= LO_THR_RST;
      snk_thr_r <= SNK_THR_RST;
      stop_thr_r <= STOP_THR_RST;
    end else begin
      if (wr_hit(OFS_PORT_CTRL)) begin
        {wd_en_r, plug_orientation_r} <= hwdata_i[1:0];
      end
      if (wr_hit(OFS_MSG_HDR)) begin
        msg_role_r <= hwdata_i[0];
      end
      if (wr_hit(OFS_PWR_MASK)) begin
        pmask_r <= hwdata_i[3:0];
      end
      if (wr_hit(OFS_ALERT_MASK)) begin
        amask_r <= hwdata_i[3:0];
      end
      if (wr_hit(OFS_HI_THR)) begin
        hi_thr_r <= hwdata_i[9:0];
      end
      if (wr_hit(OFS_LO_THR)) begin
        lo_thr_r <= hwdata_i[9:0];
      end
      if (wr_hit(OFS_SNK_THR)) begin
        snk_thr_r <= hwdata_i[9:0];
      end
      if (wr_hit(OFS_STOP_THR)) begin
        stop_thr_r <= hwdata_i[9:0];
      end
    end
  end

  // Software write wins over the automatic stop in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pctrl_r <= '0;
    end else if (wr_hit(OFS_PWR_CTRL)) begin
      pctrl_r <= pwr_ctrl_t'(hwdata_i[3:0]);
    end else if (pctrl_r.forced_discharge && new_sample_r && (path_r != '0) && volt_r <= stop_thr_r) begin
      pctrl_r.forced_discharge <= 1'b0;
    end
  end

  // Safety events win over software writes to paths and role bits
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      path_r <= '0;
      role_r <= ROLE_RST;
    end else begin
      if (wd_expire_r) begin
        role_r <= ROLE_OPEN_ALL;
      end else if (wr_hit(OFS_ROLE)) begin
        role_r <= hwdata_i[3:0];
      end
      if (wd_expire_r || disconnect) begin
        path_r <= '0;
      end else if (wr_hit(OFS_COMMAND)) begin
        path_r <= path_t'(hwdata_i[1:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, alarms and alerts (set wins over write-one-to-clear)
  // ----------------------------------------------------------------
  assign pstat = {full_discharge_load_o, path_r.sink_on, path_r.source_on, vp_f_r};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      alert_r <= 3'h0;
      fault_r <= 2'h0;
      pp_alert_r <= 1'b0;
      interrupt_pin_n_o <= 1'b1;
    end else begin
      pp_alert_r <= |(pstat & pmask_r);
      interrupt_pin_n_o <= ~|({alert_r, pp_alert_r} & amask_r);
      alert_r <= alert_r & ~(wr_hit(OFS_ALERT) ? hwdata_i[3:1] : 3'h0);
      fault_r <= fault_r & ~(wr_hit(OFS_FAULT) ? hwdata_i[1:0] : 2'h0);
      if (new_sample_r && !pctrl_r.alarm_disable && volt_r > hi_thr_r) begin
        alert_r[ALERT_HI] <= 1'b1;
      end
      if (new_sample_r && !pctrl_r.alarm_disable && volt_r < lo_thr_r) begin
        alert_r[ALERT_LO] <= 1'b1;
      end
      if (disc_timeout || safe5_late) begin
        alert_r[ALERT_FAULT] <= 1'b1;
        fault_r[FAULT_DISCH] <= 1'b1;
      end
      if (wd_expire_r) begin
        alert_r[ALERT_FAULT] <= 1'b1;
        fault_r[FAULT_IFACE] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Disconnect detection and automatic discharge
  // ----------------------------------------------------------------
  assign src_disc = path_r.source_on && ((plug_orientation_r ? cc2_f_r : cc1_f_r) == CC_SRC_OPEN);
  // Sink: high-voltage contract uses the threshold filter, else bus-present falling
  assign snk_disc = !msg_role_r && path_r.sink_on &&
                    (hv_sink_r ? (low_cnt_r == DISC_FILTER_CYC - 1) : (vp_prev_r && !vp_f_r));
  assign disconnect = pctrl_r.automatic_discharge_enable && state_r == DC_WATCH && (src_disc || snk_disc);
  assign auto_bleed = pctrl_r.automatic_discharge_enable && !msg_role_r && path_r.sink_on &&
                      hv_sink_r && volt_r >= snk_thr_r;
  assign disc_timeout = state_r == DC_DISCH && disc_cnt_r == ZERO_VOLT_CYC - 1;
  assign safe5_late = state_r == DC_DISCH && disc_cnt_r == SAFE5V_CYC - 1 && volt_r > SAFE5V_CODE;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hv_sink_r <= 1'b0;
      low_cnt_r <= 32'h0;
    end else begin
      if (msg_role_r || !path_r.sink_on) begin
        hv_sink_r <= 1'b0;
      end else if (new_sample_r && volt_r > SAFE5V_CODE) begin
        hv_sink_r <= 1'b1;
      end
      // Filter rejects single low samples yet ends well inside the detect budget
      if (volt_r >= snk_thr_r || !hv_sink_r || low_cnt_r == DISC_FILTER_CYC - 1) begin
        low_cnt_r <= 32'h0;
      end else begin
        low_cnt_r <= low_cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= DC_WATCH;
      disc_cnt_r <= 32'h0;
    end else begin
      unique case (state_r)
        DC_WATCH: begin
          disc_cnt_r <= 32'h0;
          if (disconnect) begin
            state_r <= DC_DISCH;
          end
        end
        DC_DISCH: begin
          // Counter stops one past the deadline so the fault fires once
          if (disc_cnt_r != ZERO_VOLT_CYC) begin
            disc_cnt_r <= disc_cnt_r + 32'h1;
          end
          if (new_sample_r && volt_r < SAFE0V_CODE) begin
            state_r <= DC_WATCH;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Alert watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wd_cnt_r <= 32'h0;
      wd_expire_r <= 1'b0;
      wd_disch_r <= 1'b0;
    end else begin
      wd_expire_r <= 1'b0;
      // Any access restarts; a still pending alert starts it again
      if (!wd_en_r || access || (!(|({alert_r, pp_alert_r} & amask_r)) && interrupt_pin_n_o)) begin
        wd_cnt_r <= 32'h0;
      end else if (wd_cnt_r == WATCHDOG_CYC - 1) begin
        wd_cnt_r <= 32'h0;
        wd_expire_r <= 1'b1;
      end else begin
        wd_cnt_r <= wd_cnt_r + 32'h1;
      end
      if (wd_expire_r) begin
        wd_disch_r <= 1'b1;
      end else if (new_sample_r && volt_r < SAFE0V_CODE) begin
        wd_disch_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      source_path_o <= 1'b0;
      sink_path_o <= 1'b0;
      bleed_load_o <= 1'b0;
      full_discharge_load_o <= 1'b0;
      cc_term_enable_o <= 1'b1;
      role_control_o <= ROLE_RST;
    end else begin
      source_path_o <= path_r.source_on;
      sink_path_o <= path_r.sink_on;
      bleed_load_o <= pctrl_r.bleed_discharge_enable || auto_bleed;
      // Load slope is set by the analog load, not by this logic
      full_discharge_load_o <= pctrl_r.forced_discharge || state_r == DC_DISCH || wd_disch_r;
      cc_term_enable_o <= state_r != DC_DISCH;
      role_control_o <= role_r;
    end
  end

endmodule
`default_nettype wire

// File: rtl/vbus_pkg.sv
// Purpose: Shared constants and types for the VBUS monitor and discharge control
// Assumes: 50 MHz core clock, AHB-Lite register access, 10-bit VBUS codes
// Notes: One code step of the bus voltage is 25 mV
package vbus_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned SAMPLE_US = 100;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_US * CYC_PER_US;
  localparam int unsigned WATCHDOG_MS = 10;
  localparam int unsigned WATCHDOG_CYCLES = WATCHDOG_MS * CYC_PER_MS;
  localparam int unsigned SAFE5V_MS = 275;
  localparam int unsigned SAFE5V_CYCLES = SAFE5V_MS * CYC_PER_MS;
  localparam int unsigned ZERO_VOLT_MS = 650;
  localparam int unsigned ZERO_VOLT_CYCLES = ZERO_VOLT_MS * CYC_PER_MS;
  localparam int unsigned DISC_DETECT_MS = 6;
  localparam int unsigned DISC_DETECT_CYCLES = DISC_DETECT_MS * CYC_PER_MS;
  // Filter uses half the detect budget, leaving room for sampling delay
  localparam int unsigned DISC_FILTER_CYCLES = DISC_DETECT_CYCLES / 2;

  // ----------------------------------------------------------------
  // Voltage codes (25 mV per step)
  // ----------------------------------------------------------------
  localparam int unsigned VBUS_LSB_MV = 25;
  localparam logic [9:0] SAFE0V_CODE = 10'h020;
  localparam logic [9:0] SAFE5V_CODE = 10'h0dc;
  localparam logic [1:0] CC_SRC_OPEN = 2'h0;
  localparam logic [3:0] ROLE_OPEN_ALL = 4'hf;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
  localparam logic [7:0] OFS_PORT_CTRL = 8'h04;
  localparam logic [7:0] OFS_PWR_STAT = 8'h08;
  localparam logic [7:0] OFS_PWR_MASK = 8'h0c;
  localparam logic [7:0] OFS_ALERT = 8'h10;
  localparam logic [7:0] OFS_ALERT_MASK = 8'h14;
  localparam logic [7:0] OFS_FAULT = 8'h18;
  localparam logic [7:0] OFS_VOLT = 8'h1c;
  localparam logic [7:0] OFS_HI_THR = 8'h20;
  localparam logic [7:0] OFS_LO_THR = 8'h24;
  localparam logic [7:0] OFS_SNK_THR = 8'h28;
  localparam logic [7:0] OFS_STOP_THR = 8'h2c;
  localparam logic [7:0] OFS_MSG_HDR = 8'h30;
  localparam logic [7:0] OFS_COMMAND = 8'h34;
  localparam logic [7:0] OFS_ROLE = 8'h38;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ALERT_PORT_PWR = 0;
  localparam int unsigned ALERT_HI = 1;
  localparam int unsigned ALERT_LO = 2;
  localparam int unsigned ALERT_FAULT = 3;
  localparam int unsigned FAULT_DISCH = 0;
  localparam int unsigned FAULT_IFACE = 1;
  localparam logic [9:0] HI_THR_RST = 10'h3ff;
  localparam logic [9:0] LO_THR_RST = 10'h000;
  localparam logic [9:0] SNK_THR_RST = 10'h000;
  localparam logic [9:0] STOP_THR_RST = 10'h020;
  localparam logic [3:0] ROLE_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'hf;

  typedef struct packed {
    logic alarm_disable;
    logic automatic_discharge_enable;
    logic forced_discharge;
    logic bleed_discharge_enable;
  } pwr_ctrl_t;

  typedef struct packed {
    logic sink_on;
    logic source_on;
  } path_t;

  typedef enum logic [1:0] {
    HTRANS_IDLE = 2'h0,
    HTRANS_BUSY = 2'h1,
    HTRANS_NONSEQ = 2'h2,
    HTRANS_SEQ = 2'h3
  } htrans_t;

endpackage

// File: sim/vbus_monitor_assertions.sv
// Purpose: Port-level checks of the VBUS block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every instance
`timescale 1ns/1ns
`default_nettype none
module vbus_monitor_assertions #(
  parameter int unsigned SAMPLE_CYC = 20,
  parameter int unsigned ZERO_VOLT_CYC = 600
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic adc_sample_o,
  input wire logic source_path_o,
  input wire logic sink_path_o,
  input wire logic bleed_load_o,
  input wire logic full_discharge_load_o,
  input wire logic cc_term_enable_o,
  input wire logic [3:0] role_control_o,
  input wire logic interrupt_pin_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // --------
  // Helper counters
  // --------
  int unsigned gap_r, fl_r;
  logic seen_r;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      gap_r <= 0;
      seen_r <= 1'b0;
    end else if (adc_sample_o) begin
      gap_r <= 1;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 1;
    end
  end
  // Stops one past the mark
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || cc_term_enable_o) begin
      fl_r <= 0;
    end else if (fl_r < ZERO_VOLT_CYC + 9) begin
      fl_r <= fl_r + 1;
    end
  end
  sequence long_disch_s;
    fl_r == ZERO_VOLT_CYC + 8;
  endsequence
  // --------
  // Assertions
  // --------
  sample_gap_a: assert property (adc_sample_o && seen_r |-> gap_r == SAMPLE_CYC)
    else $error("sample spacing wrong");
  sample_pulse_a: assert property (adc_sample_o |=> !adc_sample_o)
    else $error("sample pulse too long");
  fail_flag_a: assert property (long_disch_s |-> !interrupt_pin_n_o)
    else $error("no fault after long discharge");
  term_paths_a: assert property (!cc_term_enable_o |-> !source_path_o && !sink_path_o)
    else $error("path on while terms withheld");
  read_hold_a: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=> $stable(hrdata_o))
    else $error("read data moved");
  reset_vals_a: assert property ($fell(rst_i) |-> !source_path_o && !sink_path_o && !bleed_load_o
    && !full_discharge_load_o && cc_term_enable_o && role_control_o == 4'h0 && interrupt_pin_n_o)
    else $error("bad reset outputs");
  ready_high_a: assert property (hreadyout_o)
    else $error("wait state seen");
  resp_okay_a: assert property (!hresp_o)
    else $error("response not okay");
endmodule
bind vbus_monitor_discharge_ctrl vbus_monitor_assertions #(
  .SAMPLE_CYC(SAMPLE_CYC), .ZERO_VOLT_CYC(ZERO_VOLT_CYC)
) chk_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .adc_sample_o(adc_sample_o), .source_path_o(source_path_o), .sink_path_o(sink_path_o),
  .bleed_load_o(bleed_load_o), .full_discharge_load_o(full_discharge_load_o),
  .cc_term_enable_o(cc_term_enable_o), .role_control_o(role_control_o), .interrupt_pin_n_o(interrupt_pin_n_o)
);
`default_nettype wire

// File: sim/vbus_converter_model.sv
// Purpose: Converter and VBUS plant seen by the block
// Assumes: Result three cycles after each request, 25 mV per code
// Notes: Full load drops 16 codes a sample unless stuck
`timescale 1ns/1ns
`default_nettype none
module vbus_converter_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire logic full_load_i,
  input wire logic stuck_i,
  input wire logic set_i,
  input wire logic [9:0] set_code_i,
  output logic valid_o,
  output logic [9:0] result_o,
  output logic present_o
);
  logic [9:0] code_r;
  logic [1:0] dly_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_r <= 10'h000;
      dly_r <= 2'h0;
      valid_o <= 1'b0;
      result_o <= 10'h000;
    end else begin
      dly_r <= {dly_r[0], sample_i};
      valid_o <= dly_r[1];
      // Junk between results
      result_o <= dly_r[1] ? code_r : ~result_o;
      if (set_i) begin
        code_r <= set_code_i;
      end else if (dly_r[1] && full_load_i && !stuck_i) begin
        code_r <= (code_r > 10'h010) ? code_r - 10'h010 : 10'h000;
      end
    end
  end
  // Presence comparator trips near 4.5 V
  assign present_o = (code_r > 10'h0b4);
endmodule
`default_nettype wire

// File: sim/vbus_monitor_discharge_ctrl_tb_top.sv
// Purpose: Self-checking bench for the VBUS block
// Assumes: Shortened timers, bench is the AHB-Lite master
// Notes: Scenarios share the plant state
`timescale 1ns/1ns
`default_nettype none
module vbus_monitor_discharge_ctrl_tb_top;
  import vbus_pkg::*;
  localparam int ZV = 600;
  logic clk, rst, hsel, hwrite, hrdy, hresp, smp, vld, pres, set_v, stuck;
  logic src, snk, bleed, full, term, pin_n;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, cc1, cc2;
  logic [9:0] res, code;
  logic [3:0] role;
  int fail_count = 0;
  int comparisons = 0;
  vbus_monitor_discharge_ctrl #(.SAMPLE_CYC(20), .WATCHDOG_CYC(200), .SAFE5V_CYC(300), .ZERO_VOLT_CYC(ZV),
    .DISC_FILTER_CYC(10)) dut (.ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .adc_sample_o(smp), .adc_valid_i(vld),
    .adc_result_i(res), .bus_power_present_i(pres), .cc1_pin_state_i(cc1), .cc2_pin_state_i(cc2),
    .source_path_o(src), .sink_path_o(snk), .bleed_load_o(bleed), .full_discharge_load_o(full),
    .cc_term_enable_o(term), .role_control_o(role), .interrupt_pin_n_o(pin_n));
  vbus_converter_model conv (.clk_i(clk), .rst_i(rst), .sample_i(smp), .full_load_i(full),
    .stuck_i(stuck), .set_i(set_v), .set_code_i(code), .valid_o(vld), .result_o(res), .present_o(pres));
  always #10 clk = ~clk;
  // --------
  // Bus and compare tasks
  // --------
  task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // Each phase held until hready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h0, a}, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, {24'h0, a}, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic lvl(input logic [9:0] c);
    @(posedge clk);
    set_v <= 1'b1;
    code <= c;
    @(posedge clk);
    set_v <= 1'b0;
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_reset;
    rd(OFS_HI_THR, 32'hffffffff, {22'h0, HI_THR_RST});
    rd(OFS_STOP_THR, 32'hffffffff, {22'h0, STOP_THR_RST});
    bus(1'b1, 32'h100, 32'hffffffff, q);
    bus(1'b0, 32'h100, 32'h0, q);
    chk(q, 32'h0);
  endtask
  task automatic t_alarm;
    lvl(10'h150);
    cyc(60);
    rd(OFS_VOLT, 32'h3ff, 32'h150);
    wr(OFS_HI_THR, 32'h100);
    cyc(60);
    rd(OFS_ALERT, 32'h6, 32'h2);
    chk1(pin_n, 1'b0);
    wr(OFS_PWR_CTRL, 32'h8);
    wr(OFS_ALERT, 32'he);
    cyc(60);
    rd(OFS_ALERT, 32'h6, 32'h0);
    wr(OFS_HI_THR, 32'h3ff);
    wr(OFS_PWR_CTRL, 32'h0);
    wr(OFS_LO_THR, 32'h200);
    cyc(60);
    rd(OFS_ALERT, 32'h6, 32'h4);
    wr(OFS_LO_THR, 32'h0);
    wr(OFS_PWR_MASK, 32'h0);
    cyc(3);
    rd(OFS_ALERT, 32'h1, 32'h0);
    wr(OFS_PWR_MASK, 32'h1);
    cyc(3);
    rd(OFS_ALERT, 32'h1, 32'h1);
  endtask
  task automatic t_manual;
    wr(OFS_PWR_CTRL, 32'h1);
    cyc(3);
    chk1(bleed, 1'b1);
    wr(OFS_COMMAND, 32'h1);
    wr(OFS_STOP_THR, 32'h80);
    lvl(10'h100);
    wr(OFS_PWR_CTRL, 32'h2);
    cyc(3);
    chk1(full, 1'b1);
    cyc(400);
    chk1(full, 1'b0);
    rd(OFS_PWR_CTRL, 32'h2, 32'h0);
  endtask
  task automatic t_src_disc;
    lvl(10'h100);
    stuck <= 1'b1;
    wr(OFS_PORT_CTRL, 32'h1);
    wr(OFS_PWR_CTRL, 32'h4);
    cc1 <= 2'h0;
    cyc(20);
    chk1(src, 1'b1);
    @(posedge clk) cc2 <= CC_SRC_OPEN;
    cyc(10);
    chk1(full, 1'b1);
    chk1(src, 1'b0);
    chk1(term, 1'b0);
    cyc(ZV + 50);
    rd(OFS_FAULT, 32'h1, 32'h1);
    chk1(full, 1'b1);
    chk({28'h0, role}, 32'h0);
    stuck <= 1'b0;
    cyc(400);
    chk1(full, 1'b0);
    chk1(term, 1'b1);
    wr(OFS_PWR_CTRL, 32'h0);
    cc1 <= 2'h1;
    cc2 <= 2'h1;
  endtask
  task automatic t_sink;
    lvl(10'h180);
    wr(OFS_MSG_HDR, 32'h0);
    wr(OFS_SNK_THR, 32'h150);
    wr(OFS_COMMAND, 32'h2);
    wr(OFS_PWR_CTRL, 32'h4);
    cyc(60);
    chk1(bleed, 1'b1);
    chk1(snk, 1'b1);
    lvl(10'h140);
    cyc(60);
    chk1(full, 1'b1);
    chk1(snk, 1'b0);
    cyc(600);
    chk1(full, 1'b0);
    wr(OFS_PWR_CTRL, 32'h0);
  endtask
  task automatic t_wdog;
    wr(OFS_FAULT, 32'h3);
    wr(OFS_ALERT, 32'he);
    wr(OFS_COMMAND, 32'h1);
    lvl(10'h100);
    wr(OFS_PORT_CTRL, 32'h2);
    repeat (6) begin
      cyc(100);
      rd(OFS_ROLE, 32'hf, 32'h0);
    end
    cyc(300);
    chk({28'h0, role}, {28'h0, ROLE_OPEN_ALL});
    chk1(src, 1'b0);
    chk1(full, 1'b1);
    rd(OFS_FAULT, 32'h2, 32'h2);
  endtask
  // --------
  // Main sequence and watchdog
  // --------
  initial begin
    {clk, hsel, hwrite, set_v, stuck} = 5'h0;
    rst = 1'b1;
    htrans = HTRANS_IDLE;
    {haddr, hwdata} = 64'h0;
    {cc1, cc2} = 4'h5;
    code = 10'h000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_alarm();
    t_manual();
    t_src_disc();
    t_sink();
    t_wdog();
    end_of_test();
  end
  // Run needs about 3500 cycles
  initial begin
    #500000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
